// [dv/sbsc_ctrl_assertions.sv]
`timescale 1ns/1ps
`include "sbsc_params.svh"
module sbsc_ctrl_checker
	import sbsc_pkg::*;
(
	// Watched ports
	input wire logic mclk,
	input wire logic srst,
	input wire sbsc_ctl_t ctl,
	input wire logic [`SBSC_ADDR_W-1:0] addr,
	input wire logic burst_order_strap,
	input wire logic out_enable_n,
	input wire logic [15:0] data_io_oe,
	input wire logic [`SBSC_ADDR_W-1:0] mem_rd_addr,
	input wire sbsc_wr_t mem_wr
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	wire sel = !ctl.chip_sel_primary_n && ctl.chip_sel_secondary && !ctl.chip_sel_tertiary_n;
	wire cs = !ctl.cache_ctrl_addr_strobe_n && ctl.cpu_addr_strobe_n && sel;
	wire rd = cs && ctl.all_bytes_write_n && ctl.byte_write_qualify_n;
	wire nostb = ctl.cpu_addr_strobe_n && ctl.cache_ctrl_addr_strobe_n;
	all_lanes_a: assert property (cs && !ctl.all_bytes_write_n |=> mem_wr.lane_we == 2'h3)
		else $error("global write lanes wrong");
	lane_qual_a: assert property (cs && ctl.all_bytes_write_n |=> mem_wr.lane_we ==
		($past(ctl.byte_write_qualify_n) ? 2'h0 : ~$past({ctl.byte_lane_b_write_sel_n, ctl.byte_lane_a_write_sel_n})))
		else $error("byte lanes wrong");
	cpu_wins_a: assert property (!ctl.cpu_addr_strobe_n && sel |=> mem_wr.lane_we == 2'h0)
		else $error("write on processor start");
	cpu_ignored_a: assert property (ctl.chip_sel_primary_n && !ctl.cpu_addr_strobe_n &&
		ctl.cache_ctrl_addr_strobe_n && ctl.burst_advance_n |=> $stable(mem_rd_addr)) else $error("address moved");
	addr_load_a: assert property (!nostb && sel |=> mem_rd_addr == $past(addr))
		else $error("address not loaded");
	burst_step_a: assert property (!burst_order_strap && rd ##1 (nostb && !ctl.burst_advance_n) |=>
		mem_rd_addr[1:0] == $past(mem_rd_addr[1:0]) + 2'h1 && $stable(mem_rd_addr[18:2])) else $error("bad step");
	oe_gate_a: assert property (out_enable_n |-> data_io_oe == '0) else $error("driven with enable high");
	first_read_a: assert property (!ctl.cache_ctrl_addr_strobe_n && !sel ##1 rd |=> data_io_oe == '0)
		else $error("first read driven");
	write_float_a: assert property (mem_wr.lane_we != 2'h0 |-> data_io_oe == '0) else $error("driven in write");
	desel_float_a: assert property (!ctl.cache_ctrl_addr_strobe_n && !sel |=> data_io_oe == '0)
		else $error("driven after deselect");
endmodule
bind sbsc_ctrl sbsc_ctrl_checker u_chk (.mclk, .srst, .ctl, .addr, .burst_order_strap, .out_enable_n,
	.data_io_oe, .mem_rd_addr, .mem_wr);

// [dv/sbsc_host_model.sv]
`timescale 1ns/1ps
module sbsc_host_model
	import sbsc_pkg::*;
(
	// Clock
	input wire logic mclk,
	// Pins towards the device
	output sbsc_ctl_t ctl,
	output logic [18:0] addr,
	output logic [15:0] wdata
);
	// ****************************************
	// Bus cycle
	// ****************************************
	// Data flips every cycle so a stale sample never passes for fresh data.
	initial
	begin
		ctl = 10'h3fe;
		addr = 19'h00000;
		wdata = 16'h5a3c;
	end
	task automatic cyc(input logic [9:0] c, input logic [18:0] a);
		@(posedge mclk);
		#1;
		ctl = c;
		addr = a;
		wdata = ~wdata;
	endtask
endmodule

// [dv/tb.sv]
`timescale 1ns/1ps
module tb
	import sbsc_pkg::*;
;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic oe_n = 1'b0;
	logic strap = 1'b0;
	int n_fail = 0;
	int total_checks = 0;
	int cycles = 0;
	sbsc_ctl_t ctl;
	logic [18:0] addr;
	logic [18:0] mem_rd_addr;
	logic [15:0] wdata;
	logic [15:0] dout;
	logic [15:0] doe;
	logic [1:0] pout;
	logic [1:0] poe;
	sbsc_wr_t mem_wr;
	wire logic [15:0] mem_rd_data = {mem_rd_addr[7:0], ~mem_rd_addr[7:0]};
	sbsc_host_model host (.mclk(mclk), .ctl(ctl), .addr(addr), .wdata(wdata));
	sbsc_ctrl uut (.mclk(mclk), .srst(srst), .ctl(ctl), .addr(addr), .burst_order_strap(strap), .out_enable_n(oe_n),
		.data_io_i(wdata), .data_io_o(dout), .data_io_oe(doe), .parity_io_i(wdata[1:0]), .parity_io_o(pout),
		.parity_io_oe(poe), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
		.mem_rd_parity(mem_rd_addr[1:0]), .mem_wr(mem_wr));
	initial forever #4 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_fail++;
			complete_run();
		end
	end
	task automatic judge(input bit ok, input string what);
		total_checks++;
		if (!ok)
		begin
			n_fail++;
			$display("BAD %0t %s", $time, what);
		end
	endtask
	task automatic chk_addr(input logic [18:0] g, input logic [18:0] e);
		judge(g === e, $sformatf("address got %h want %h", g, e));
	endtask
	task automatic chk_oe(input logic [17:0] g, input logic [17:0] e);
		judge(g === e, $sformatf("drive enables got %h want %h", g, e));
	endtask
	task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
		judge(g === e, $sformatf("data got %h want %h", g, e));
	endtask
	task automatic chk_pair(input logic [1:0] g, input logic [1:0] e);
		judge(g === e, $sformatf("lane bits got %h want %h", g, e));
	endtask
	task automatic complete_run();
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic s_read();
		host.cyc(10'h2fe, 19'h00000);
		host.cyc(10'h2fa, 19'h12343);
		host.cyc(10'h37e, 19'h00000);
		chk_addr(mem_rd_addr, 19'h12343);
		chk_oe({poe, doe}, 18'h00000);
		chk_pair(pout, 2'h3);
		host.cyc(10'h37e, 19'h00000);
		chk_addr(mem_rd_addr, 19'h12340);
		chk_oe({poe, doe}, 18'h3ffff);
		chk_word(dout, 16'h40bf);
		oe_n = 1'b1;
		#1;
		chk_oe({poe, doe}, 18'h00000);
		host.cyc(10'h3fe, 19'h00000);
		chk_addr(mem_rd_addr, 19'h12341);
		oe_n = 1'b0;
	endtask
	task automatic s_write();
		logic [9:0] wc[5] = '{10'h2ba, 10'h2d2, 10'h2ca, 10'h2e2, 10'h0ba};
		logic [1:0] we[5] = '{2'h3, 2'h1, 2'h2, 2'h0, 2'h0};
		logic [17:0] oe[5] = '{18'h00000, 18'h00000, 18'h00000, 18'h3ffff, 18'h3ffff};
		logic [15:0] d;
		for (int i = 0; i < 5; i++)
		begin
			host.cyc(wc[i], 19'h2a5c3);
			d = host.wdata;
			host.cyc(10'h3fe, 19'h00000);
			chk_pair(mem_wr.lane_we, we[i]);
			chk_oe({poe, doe}, oe[i]);
			if (we[i] != 2'h0)
			begin
				chk_addr(mem_wr.addr, 19'h2a5c3);
				chk_word(mem_wr.data, d);
				chk_pair(mem_wr.parity, d[1:0]);
			end
		end
	endtask
	task automatic s_ignore();
		host.cyc(10'h2fa, 19'h00005);
		host.cyc(10'h1fe, 19'h7ffff);
		host.cyc(10'h3fe, 19'h00000);
		chk_addr(mem_rd_addr, 19'h00005);
	endtask
	task automatic s_select();
		chk_oe({poe, doe}, 18'h3ffff);
		host.cyc(10'h2f8, 19'h01234);
		host.cyc(10'h2fa, 19'h01234);
		chk_oe({poe, doe}, 18'h00000);
		host.cyc(10'h3fe, 19'h00000);
		chk_oe({poe, doe}, 18'h00000);
		chk_addr(mem_rd_addr, 19'h01234);
		host.cyc(10'h3fe, 19'h00000);
		chk_oe({poe, doe}, 18'h3ffff);
		host.cyc(10'h2fb, 19'h00000);
		host.cyc(10'h3fe, 19'h00000);
		chk_oe({poe, doe}, 18'h00000);
	endtask
	task automatic s_interleave();
		strap = 1'b1;
		repeat (2) host.cyc(10'h3fe, 19'h00000);
		host.cyc(10'h2fa, 19'h0abc5);
		host.cyc(10'h37e, 19'h00000);
		chk_addr(mem_rd_addr, 19'h0abc5);
		host.cyc(10'h37e, 19'h00000);
		chk_addr(mem_rd_addr, 19'h0abc4);
		host.cyc(10'h3fe, 19'h00000);
		chk_addr(mem_rd_addr, 19'h0abc7);
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		repeat (20) @(posedge mclk);
		#1;
		srst = 1'b0;
		s_read();
		s_write();
		s_ignore();
		s_select();
		s_interleave();
		complete_run();
	end
endmodule

// [logic/sbsc_ctrl.sv]
`timescale 1ns/1ps
`include "sbsc_params.svh"

// How it works
// - A lane select writes its lane only when the byte write qualifier is low.
// - All-bytes write low writes both lanes, ignoring lane selects and qualifier.
// - Every synchronous pin is taken only at the rising edge of mclk.
// - Each edge with burst advance low, during an access and with no strobe taken, moves the burst counter one position.
// - Selected only with primary low, secondary high and tertiary low together.
// - A processor strobe while primary select is high is ignored entirely.
// - A taken strobe that selects the chip loads the address and puts its two low bits in the counter.
// - When both strobes are low with primary select low, only the processor strobe is acted on.
// - Output enable low drives the data pins; high leaves them as inputs.
// - The first read clock after deselect keeps the data pins undriven.
// - Order strap low gives linear bursts, high gives interleaved; held static.
// - Read data shows the location addressed at the preceding rising edge.
// - Data pins float during write data phases and while deselected.
module sbsc_ctrl
	import sbsc_pkg::*;
#(
	parameter int ADDR_W = `SBSC_ADDR_W,
	parameter int LANES = `SBSC_LANES,
	parameter int LANE_DATA_W = `SBSC_LANE_DATA_W,
	parameter bit HAS_TERTIARY_SEL = 1'b1
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Synchronous control and address pins
	input wire sbsc_ctl_t ctl,
	input wire logic [ADDR_W-1:0] addr,
	// Static burst order strap
	input wire logic burst_order_strap,
	// Asynchronous output enable
	input wire logic out_enable_n,
	// Data pins
	input wire logic [LANES*LANE_DATA_W-1:0] data_io_i,
	output logic [LANES*LANE_DATA_W-1:0] data_io_o,
	output logic [LANES*LANE_DATA_W-1:0] data_io_oe,
	// Parity pins
	input wire logic [LANES-1:0] parity_io_i,
	output logic [LANES-1:0] parity_io_o,
	output logic [LANES-1:0] parity_io_oe,
	// Array port
	output logic [ADDR_W-1:0] mem_rd_addr,
	input wire logic [LANES*LANE_DATA_W-1:0] mem_rd_data,
	input wire logic [LANES-1:0] mem_rd_parity,
	output sbsc_wr_t mem_wr
);

	localparam int BW = `SBSC_BURST_W;

	// ****************************************
	// Decoding helpers
	// ****************************************
	function automatic logic [BW-1:0] burst_pos(
		input logic [BW-1:0] base,
		input logic [BW-1:0] step,
		input logic interleave
	);
		logic [BW-1:0] pos;
		pos = interleave ? (base ^ step) : BW'(base + step);
		return pos;
	endfunction

	function automatic logic [LANES-1:0] lane_enables(
		input logic all_n,
		input logic qualify_n,
		input logic [LANES-1:0] sel_n
	);
		logic [LANES-1:0] en;
		en = {LANES{1'b0}};
		if (!all_n)
		begin
			en = {LANES{1'b1}};
		end
		else if (!qualify_n)
		begin
			en = ~sel_n;
		end
		return en;
	endfunction

	// ****************************************
	// Strap capture
	// ****************************************
	// The strap is a pin outside any clock, so it is taken through two flops.
	logic strap_meta;
	logic strap_sync;

	always_ff @(posedge mclk)
	begin
		strap_meta <= burst_order_strap;
		strap_sync <= strap_meta;
	end

	// ****************************************
	// Strobe and select decode
	// ****************************************
	wire tertiary_ok = HAS_TERTIARY_SEL ? ~ctl.chip_sel_tertiary_n : 1'b1;
	wire chip_selected = ~ctl.chip_sel_primary_n & ctl.chip_sel_secondary & tertiary_ok;
	wire cpu_take = ~ctl.cpu_addr_strobe_n & ~ctl.chip_sel_primary_n;
	wire ctrl_take = ~ctl.cache_ctrl_addr_strobe_n & ~cpu_take;
	wire strobe_take = cpu_take | ctrl_take;
	wire new_access = strobe_take & chip_selected;
	wire new_deselect = strobe_take & ~chip_selected;
	wire [LANES-1:0] sel_n = {ctl.byte_lane_b_write_sel_n, ctl.byte_lane_a_write_sel_n};
	wire [LANES-1:0] lanes_req = lane_enables(ctl.all_bytes_write_n, ctl.byte_write_qualify_n, sel_n);

	// ****************************************
	// Access state
	// ****************************************
	sbsc_phase_t phase;
	sbsc_phase_t next_phase;
	logic [ADDR_W-1:BW] addr_hi;
	logic [BW-1:0] burst_base;
	logic [BW-1:0] burst_step;
	logic first_read;
	localparam logic [ADDR_W-1:0] RST_ADDR = ADDR_W'(`SBSC_RST_ADDR);

	wire active = (phase != SBSC_IDLE);
	wire [BW-1:0] cur_pos = burst_pos(burst_base, burst_step, strap_sync);
	wire [ADDR_W-1:0] cur_addr = {addr_hi, cur_pos};
	// A processor-strobe start carries no write; write controls count on later edges.
	wire start_writes = ctrl_take & new_access & (|lanes_req);
	wire cont_writes = ~strobe_take & active & (|lanes_req);
	wire [LANES-1:0] next_lanes = (start_writes | cont_writes) ? lanes_req : {LANES{1'b0}};
	wire [ADDR_W-1:0] next_wr_addr = start_writes ? addr : cur_addr;
	wire step_now = ~strobe_take & active & ~ctl.burst_advance_n;
	wire [BW-1:0] next_step = new_access ? BW'(`SBSC_RST_BURST_STEP) : (step_now ? BW'(burst_step + 1'b1) : burst_step);

	// A strobe settles the phase outright; between strobes the write controls choose write or read.
	always_comb
	begin
		next_phase = phase;
		unique case (phase)
			SBSC_IDLE:
			begin
				if (new_deselect)
				begin
					next_phase = SBSC_IDLE;
				end
				else if (start_writes)
				begin
					next_phase = SBSC_WRITE;
				end
				else if (new_access)
				begin
					next_phase = SBSC_READ;
				end
			end
			SBSC_READ, SBSC_WRITE:
			begin
				if (new_deselect)
				begin
					next_phase = SBSC_IDLE;
				end
				else if (start_writes || cont_writes)
				begin
					next_phase = SBSC_WRITE;
				end
				else
				begin
					next_phase = SBSC_READ;
				end
			end
			default:
			begin
				next_phase = SBSC_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			phase <= SBSC_IDLE;
		end
		else
		begin
			phase <= next_phase;
		end
	end

	// The mask is set only by a start from idle, so a start that follows an active access drives at once.
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			first_read <= 1'b0;
		end
		else
		begin
			first_read <= new_access & ~active;
		end
	end

	// ****************************************
	// Address register and burst counter
	// ****************************************
	// Only a selected start loads; a strobe that deselects leaves the old address in place.
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			addr_hi <= RST_ADDR[ADDR_W-1:BW];
			burst_base <= `SBSC_RST_BURST_STEP;
		end
		else if (new_access)
		begin
			addr_hi <= addr[ADDR_W-1:BW];
			burst_base <= addr[BW-1:0];
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			burst_step <= `SBSC_RST_BURST_STEP;
		end
		else
		begin
			burst_step <= next_step;
		end
	end

	// ****************************************
	// Write path
	// ****************************************
	// Writes are committed one cycle after the sampling edge, like a self-timed write.
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			mem_wr.lane_we <= {LANES{1'b0}};
		end
		else
		begin
			mem_wr.lane_we <= next_lanes;
		end
		mem_wr.addr <= next_wr_addr;
		mem_wr.data <= data_io_i;
		mem_wr.parity <= parity_io_i;
	end

	// ****************************************
	// Read path
	// ****************************************
	// The array reads without a clock, so data follows the address registered at the last edge.
	assign mem_rd_addr = cur_addr;
	assign data_io_o = mem_rd_data;
	assign parity_io_o = mem_rd_parity;

	// Output enable acts without the clock; only the gating terms come from flops.
	wire drive_ok = (phase == SBSC_READ) & ~first_read;
	wire drive = drive_ok & ~out_enable_n;

	genvar g;
	generate
		for (g = 0; g < LANES; g++)
		begin : g_lane
			assign data_io_oe[g*LANE_DATA_W +: LANE_DATA_W] = {LANE_DATA_W{drive}};
			assign parity_io_oe[g] = drive;
		end
	endgenerate

endmodule

// [logic/sbsc_params.svh]
`ifndef SBSC_PARAMS_SVH
`define SBSC_PARAMS_SVH

// ****************************************
// Geometry
// ****************************************
`define SBSC_ADDR_W 19
`define SBSC_LANES 2
`define SBSC_LANE_DATA_W 8
`define SBSC_BURST_W 2

// ****************************************
// Reset values
// ****************************************
`define SBSC_RST_BURST_STEP 2'h0
`define SBSC_RST_ADDR 19'h00000

`endif

// [logic/sbsc_pkg.sv]
`include "sbsc_params.svh"

package sbsc_pkg;

	// ****************************************
	// Control pins sampled together each edge
	// ****************************************
	typedef struct packed {
		logic cpu_addr_strobe_n;
		logic cache_ctrl_addr_strobe_n;
		logic burst_advance_n;
		logic all_bytes_write_n;
		logic byte_write_qualify_n;
		logic byte_lane_b_write_sel_n;
		logic byte_lane_a_write_sel_n;
		logic chip_sel_primary_n;
		logic chip_sel_secondary;
		logic chip_sel_tertiary_n;
	} sbsc_ctl_t;

	// ****************************************
	// Write command towards the array
	// ****************************************
	typedef struct packed {
		logic [`SBSC_LANES-1:0] lane_we;
		logic [`SBSC_ADDR_W-1:0] addr;
		logic [`SBSC_LANES*`SBSC_LANE_DATA_W-1:0] data;
		logic [`SBSC_LANES-1:0] parity;
	} sbsc_wr_t;

	// ****************************************
	// Access phase
	// ****************************************
	typedef enum logic [1:0] {
		SBSC_IDLE = 2'h0,
		SBSC_READ = 2'h1,
		SBSC_WRITE = 2'h3
	} sbsc_phase_t;

endpackage
